// ### rtl/csamc_map.svh
// Address map, field positions, reset values and timing counts
`ifndef CSAMC_MAP_SVH
`define CSAMC_MAP_SVH
// ************************************************************
// Register addresses (word index on the plain port)
// ************************************************************
`define CSAMC_ADDR_CTRL   4'h0
`define CSAMC_ADDR_STAT   4'h1
// ************************************************************
// Control field positions
// ************************************************************
`define CSAMC_CTRL_UNI    0
`define CSAMC_CTRL_FET    1
`define CSAMC_CTRL_LSREF  2
`define CSAMC_CTRL_GAIN   4:3
`define CSAMC_CTRL_CAL    7:5
`define CSAMC_CTRL_RST    16'h0000
// ************************************************************
// Timing: trim time in microseconds, clock rate in MHz
// ************************************************************
`define CSAMC_TRIM_US     100
`define CSAMC_CLK_MHZ     200
`define CSAMC_TRIM_CYCLES (`CSAMC_TRIM_US * `CSAMC_CLK_MHZ)
`endif

// ### rtl/csamc_pkg.sv
// Types shared by the sense amplifier mode control block
package csamc_pkg;
  // ************************************************************
  // Gain codes: 5, 10, 20, 40 V/V
  // ************************************************************
  typedef enum logic [1:0] {
    CSAMC_G5,
    CSAMC_G10,
    CSAMC_G20,
    CSAMC_G40
  } csamc_gain_e;
  // Software configuration carried from the register file
  typedef struct packed {
    logic [2:0]  cal_req;    // Per-channel calibration request
    csamc_gain_e gain;       // Normal amplifier gain
    logic        lsref_sel;  // Low-side monitor reference select
    logic        fet_sel;    // Transistor drain-source sense mode
    logic        uni_sel;    // Reference divider removed
  } csamc_cfg_s;
  // Per-channel analogue controls
  typedef struct packed {
    logic        input_short;  // Amplifier inputs shorted
    logic        load_disc;    // Output load disconnected
    logic        amp_en;       // Amplifier enabled
    logic        pos_sw_node;  // Positive input on switch node
    logic        trim_active;  // Automatic trim running
    logic        trim_done;    // Trim finished, still held
    csamc_gain_e gain;         // Gain applied to the amplifier
  } csamc_chan_s;
endpackage : csamc_pkg

// ### rtl/csamc_cal.sv
// Per-channel offset calibration sequencer
module csamc_cal
  import csamc_pkg::*;
#(
  parameter logic [14:0] TRIM_CYCLES = 15'h4e20
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic cal_req,
  output logic      cal_active,
  output logic      trim_done
);
  // ************************************************************
  // Sequencer state
  // ************************************************************
  typedef enum logic [1:0] {
    CSAMC_IDLE,
    CSAMC_TRIM,
    CSAMC_HOLD
  } csamc_cal_e;

  csamc_cal_e  state_reg, state_next;  // Sequencer state
  logic [14:0] cnt_reg, cnt_next;      // Trim time counter
  logic        act_reg, act_next;      // Calibration in force
  logic        done_reg, done_next;    // Trim routine ended

  // Next state; dropping the request always ends calibration
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      CSAMC_IDLE: begin
        cnt_next = 15'h0000;
        if (cal_req) begin
          state_next = CSAMC_TRIM;
        end
      end
      CSAMC_TRIM: begin
        if (!cal_req) begin
          state_next = CSAMC_IDLE;  // [R5]
        end else if (cnt_reg == TRIM_CYCLES - 15'h0001) begin
          state_next = CSAMC_HOLD;  // [R3]
        end else begin
          cnt_next = cnt_reg + 15'h0001;
        end
      end
      CSAMC_HOLD: begin
        if (!cal_req) begin
          state_next = CSAMC_IDLE;  // [R4] [R5]
        end
      end
      default: begin
        state_next = CSAMC_IDLE;
      end
    endcase
    act_next  = (state_next != CSAMC_IDLE);  // [R2]
    done_next = (state_next == CSAMC_HOLD);
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= CSAMC_IDLE;
      cnt_reg   <= 15'h0000;
      act_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      act_reg   <= act_next;
      done_reg  <= done_next;
    end
  end

  assign cal_active = act_reg;
  assign trim_done  = done_reg;
endmodule : csamc_cal

// ### rtl/csamc_regs.sv
// Control register and read port for the plain register bus
`include "csamc_map.svh"
module csamc_regs
  import csamc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [15:0] status,
  output csamc_cfg_s       cfg,
  output logic [15:0]      rdata
);
  logic [15:0] ctrl_reg, ctrl_next;    // Control word
  logic [15:0] rdata_reg, rdata_next;  // Read data, one cycle late

  // Write decode and read mux; unmapped reads give zero
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = 16'h0000;
    if (wr_en && addr == `CSAMC_ADDR_CTRL) begin
      ctrl_next = {8'h00, wdata[7:0]};  // Upper bits reserved
    end
    if (rd_en) begin
      case (addr)
        `CSAMC_ADDR_CTRL: rdata_next = ctrl_reg;
        `CSAMC_ADDR_STAT: rdata_next = status;
        default:          rdata_next = 16'h0000;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg  <= `CSAMC_CTRL_RST;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // Field unpacking
  assign cfg.uni_sel   = ctrl_reg[`CSAMC_CTRL_UNI];
  assign cfg.fet_sel   = ctrl_reg[`CSAMC_CTRL_FET];
  assign cfg.lsref_sel = ctrl_reg[`CSAMC_CTRL_LSREF];
  assign cfg.gain      = csamc_gain_e'(ctrl_reg[`CSAMC_CTRL_GAIN]);
  assign cfg.cal_req   = ctrl_reg[`CSAMC_CTRL_CAL];
  assign rdata         = rdata_reg;
endmodule : csamc_regs

// ### rtl/csamc_top.sv
// Mode control for three low-side current sense amplifiers
//
// Operation
// R1: Divider removed means unidirectional, full reference
// R2: Calibration shorts inputs, drops load, gain 40
// R3: Automatic trim ends 100 us after request
// R4: Held in calibration while request stays high
// R5: Request low ends calibration, gain restored
// R6: Calibration forces bidirectional reference, all channels
// R7: Controller calibrates only while transistors idle
// R8: Transistor mode routes positive input to switch
// R9: Transistor mode forces negative monitor reference
// R10: Transistor mode enables amplifier after drive window
// R11: Transistor mode shorts inputs at low-side off
// R12: Four gains; bidirectional output centred half reference
// R13: Monitor reference select picks positive or negative
// R14: Per-channel overrides; reference override shared
`include "csamc_map.svh"
module csamc_top
  import csamc_pkg::*;
#(
  parameter logic [14:0] TRIM_CYCLES = 15'(`CSAMC_TRIM_CYCLES)
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        cal_pin,
  input  wire logic [2:0]  gate_drive_window,
  input  wire logic [2:0]  lowside_off_cmd,
  output csamc_chan_s [2:0] chan_ctl,
  output logic             unidirectional,
  output logic             bidir_ref,
  output logic             monitor_ref_negative
);

  // ************************************************************
  // Declarations
  // ************************************************************
  csamc_cfg_s  cfg;                 // Software configuration
  logic [15:0] status;              // Status word for reads
  logic [2:0]  cal_request;         // Combined request per channel
  logic [2:0]  cal_active;          // Calibration in force
  logic [2:0]  trim_done;           // Trim finished per channel
  logic        any_cal;             // Any channel calibrating

  // Calibration pin synchroniser
  logic        cal_s1_reg, cal_s1_next;  // First stage, not read
  logic        cal_s2_reg, cal_s2_next;  // Second stage, usable

  // Transistor sense window tracking
  logic [2:0]  win_prev_reg, win_prev_next;  // Window last cycle
  logic [2:0]  valid_reg, valid_next;        // Output valid

  // Registered analogue controls
  csamc_chan_s [2:0] ctl_reg, ctl_next;      // Per-channel controls
  logic        uni_reg, uni_next;            // Unidirectional
  logic        bid_reg, bid_next;            // Bidirectional
  logic        mref_reg, mref_next;          // Monitor on negative

  // ************************************************************
  // Register file
  // ************************************************************
  csamc_regs u_regs (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .addr   (reg_addr),
    .wdata  (reg_wdata),
    .wr_en  (reg_wr),
    .rd_en  (reg_rd),
    .status (status),
    .cfg    (cfg),
    .rdata  (reg_rdata)
  );

  // Status word: state the block itself holds
  assign status = {6'h00, bid_reg, valid_reg, trim_done, cal_active};

  // ************************************************************
  // Calibration pin synchroniser
  // ************************************************************
  // Pin is asynchronous to mclk, so two stages before use
  always_comb begin
    cal_s1_next = cal_pin;
    cal_s2_next = cal_s1_reg;
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_s1_reg <= 1'b0;
      cal_s2_reg <= 1'b0;
    end else begin
      cal_s1_reg <= cal_s1_next;
      cal_s2_reg <= cal_s2_next;
    end
  end

  // ************************************************************
  // Calibration sequencers, one per channel
  // ************************************************************
  // The pin requests every channel; register bits request one
  assign cal_request = cfg.cal_req | {3{cal_s2_reg}};  // [R2]

  for (genvar i = 0; i < 3; i++) begin : g_cal
    csamc_cal #(
      .TRIM_CYCLES (TRIM_CYCLES)
    ) u_cal (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .cal_req    (cal_request[i]),
      .cal_active (cal_active[i]),
      .trim_done  (trim_done[i])
    );
  end

  // Any channel calibrating moves the shared reference
  assign any_cal = |cal_active;  // [R6] [R14]

  // ************************************************************
  // Transistor sense window tracking
  // ************************************************************
  // Output becomes valid when the drive window falls and stays
  // valid until the low-side turn-off command. A turn-off in the
  // same cycle as the window end wins, as it is the newer event.
  always_comb begin
    win_prev_next = gate_drive_window;
    valid_next    = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (cfg.fet_sel && !lowside_off_cmd[i]) begin
        // Window end starts the valid phase
        if (win_prev_reg[i] && !gate_drive_window[i]) begin
          valid_next[i] = 1'b1;  // [R10]
        end else begin
          valid_next[i] = valid_reg[i];
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      win_prev_reg <= 3'h0;
      valid_reg    <= 3'h0;
    end else begin
      win_prev_reg <= win_prev_next;
      valid_reg    <= valid_next;
    end
  end

  // ************************************************************
  // Analogue control composition
  // ************************************************************
  // All controls are registered so the analogue switches see
  // glitch-free levels; this costs one cycle of latency.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // Calibration touches only its own channel
      ctl_next[i].load_disc   = cal_active[i];  // [R2] [R14]
      ctl_next[i].trim_active = cal_active[i] && !trim_done[i];
      ctl_next[i].trim_done   = trim_done[i];  // [R4]
      ctl_next[i].input_short = 1'b0;
      ctl_next[i].amp_en      = 1'b1;
      ctl_next[i].pos_sw_node = 1'b0;
      if (cal_active[i]) begin
        // Calibration override, held until request drops
        ctl_next[i].input_short = 1'b1;  // [R2] [R4]
        ctl_next[i].gain        = CSAMC_G40;  // [R2] [R4]
      end else begin
        // Normal gain comes back at once on exit
        ctl_next[i].gain = cfg.gain;  // [R5] [R12]
        if (cfg.fet_sel) begin
          // Input on the switch node only in the valid phase
          ctl_next[i].pos_sw_node = valid_next[i];  // [R8] [R10]
          ctl_next[i].amp_en      = valid_next[i];  // [R10]
          // Shorted from turn-off until the next window end
          ctl_next[i].input_short = lowside_off_cmd[i] ||
                                    !valid_next[i];  // [R11]
        end
      end
    end
    // Calibration forces bidirectional on every channel
    bid_next  = !cfg.uni_sel || any_cal;  // [R6] [R12]
    uni_next  = cfg.uni_sel && !any_cal;  // [R1]
    // Transistor mode overrides the monitor reference select
    mref_next = cfg.fet_sel || cfg.lsref_sel;  // [R9] [R13]
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        ctl_reg[i].input_short <= 1'b0;
        ctl_reg[i].load_disc   <= 1'b0;
        ctl_reg[i].amp_en      <= 1'b1;
        ctl_reg[i].pos_sw_node <= 1'b0;
        ctl_reg[i].trim_active <= 1'b0;
        ctl_reg[i].trim_done   <= 1'b0;
        ctl_reg[i].gain        <= CSAMC_G5;
      end
      uni_reg  <= 1'b0;
      bid_reg  <= 1'b1;
      mref_reg <= 1'b0;
    end else begin
      ctl_reg  <= ctl_next;
      uni_reg  <= uni_next;
      bid_reg  <= bid_next;
      mref_reg <= mref_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // The controller must keep transistors idle while calibrating;
  // nothing here can detect switching noise during the trim.
  assign chan_ctl             = ctl_reg;   // [R7]
  assign unidirectional       = uni_reg;
  assign bidir_ref            = bid_reg;
  assign monitor_ref_negative = mref_reg;
endmodule : csamc_top

// ### test/csamc_top_properties.sv
// Port checker for the sense amplifier mode control block
module csamc_top_properties
  import csamc_pkg::*;
#(
  parameter logic [14:0] TRIM_CYCLES = 15'h0014
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [3:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              cal_pin,
  input wire logic [2:0]        gate_drive_window,
  input wire logic [2:0]        lowside_off_cmd,
  input wire csamc_chan_s [2:0] chan_ctl,
  input wire logic              unidirectional,
  input wire logic              bidir_ref,
  input wire logic              monitor_ref_negative
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  logic        in_cal0;        // Channel 0 under calibration override
  logic [15:0] hold_cnt_reg;   // Cycles spent in calibration
  logic [15:0] hold_cnt_next;  // Next count
  assign in_cal0 = chan_ctl[0].trim_active | chan_ctl[0].trim_done;
  // Count up while overridden, so trim length is measurable
  always_comb begin
    hold_cnt_next = in_cal0 ? hold_cnt_reg + 16'h0001 : 16'h0000;
  end
  // Register only
  always_ff @(posedge mclk) begin
    hold_cnt_reg <= rst_n ? hold_cnt_next : 16'h0000;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // Assertions
  // ************************************************************
  a_cal_gain_forty: assert property (
    in_cal0 |-> chan_ctl[0].gain == CSAMC_G40 && chan_ctl[0].input_short
      && chan_ctl[0].load_disc) else $error("cal override missing");
  a_trim_length: assert property (
    $rose(chan_ctl[0].trim_done) |-> hold_cnt_reg == 16'(TRIM_CYCLES))
    else $error("trim length wrong");
  a_cal_bidir: assert property (
    $rose(in_cal0) |-> bidir_ref && !unidirectional)
    else $error("cal did not force bidirectional");
  a_uni_excl: assert property (
    unidirectional != bidir_ref) else $error("reference mode clash");
  a_mon_ref_sel: assert property (
    reg_wr && reg_addr == 4'h0 |-> ##2 monitor_ref_negative ==
      ($past(reg_wdata[1], 2) | $past(reg_wdata[2], 2)))
    else $error("monitor reference wrong");
  a_fet_enable: assert property (
    $rose(chan_ctl[0].pos_sw_node) |-> $past(gate_drive_window[0], 2)
      && !$past(gate_drive_window[0], 1)) else $error("early enable");
  a_off_short: assert property (
    chan_ctl[0].pos_sw_node && lowside_off_cmd[0] |-> ##2
      chan_ctl[0].input_short && !chan_ctl[0].pos_sw_node)
    else $error("turn-off did not short inputs");
  a_read_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
endmodule : csamc_top_properties
bind csamc_top csamc_top_properties #(.TRIM_CYCLES(TRIM_CYCLES))
  csamc_top_properties_i (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_pin(cal_pin),
  .gate_drive_window(gate_drive_window),
  .lowside_off_cmd(lowside_off_cmd), .chan_ctl(chan_ctl),
  .unidirectional(unidirectional), .bidir_ref(bidir_ref),
  .monitor_ref_negative(monitor_ref_negative));

// ### test/csamc_ctrl_model.sv
// Behavioural motor controller: drive windows and low-side turn-off
module csamc_ctrl_model #(
  parameter int WIN = 4
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] fire,
  input  wire logic [2:0] off_req,
  input  wire logic       idle,
  output logic      [2:0] gate_drive_window,
  output logic      [2:0] lowside_off_cmd
);
  int cnt [3];  // Remaining window cycles per phase
  // Window lasts WIN cycles after a fire pulse
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      // Quiet bridge while calibrating keeps noise off the inputs
      if (!rst_n || idle) begin
        cnt[i] <= 0;
        gate_drive_window[i] <= 1'b0;
        lowside_off_cmd[i] <= 1'b0;
      end else begin
        cnt[i] <= fire[i] ? WIN : (cnt[i] > 0 ? cnt[i] - 1 : 0);
        gate_drive_window[i] <= fire[i] || cnt[i] > 1;
        lowside_off_cmd[i] <= off_req[i];
      end
    end
  end
endmodule : csamc_ctrl_model

// ### test/csamc_top_tb.sv
// Self-checking bench for the sense amplifier mode control block
module csamc_top_tb
  import csamc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [14:0] TRIM = 15'h0014;  // Short trim for simulation
  logic              mclk, rst_n, reg_wr, reg_rd, cal_pin, idle;
  logic [3:0]        reg_addr;
  logic [15:0]       reg_wdata, reg_rdata, v;
  logic [2:0]        fire, off_req, gate_drive_window, lowside_off_cmd;
  csamc_chan_s [2:0] chan_ctl;
  logic              unidirectional, bidir_ref, monitor_ref_negative;
  int                compares, miscompares, cycles;
  csamc_top #(.TRIM_CYCLES(TRIM)) csamc_top_i (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cal_pin(cal_pin),
    .gate_drive_window(gate_drive_window),
    .lowside_off_cmd(lowside_off_cmd), .chan_ctl(chan_ctl),
    .unidirectional(unidirectional), .bidir_ref(bidir_ref),
    .monitor_ref_negative(monitor_ref_negative));
  csamc_ctrl_model #(.WIN(4)) csamc_ctrl_model_i (
    .mclk(mclk), .rst_n(rst_n), .fire(fire), .off_req(off_req),
    .idle(idle), .gate_drive_window(gate_drive_window),
    .lowside_off_cmd(lowside_off_cmd));
  // ************************************************************
  // Clock, timeout and report
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Whole run needs about 120 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  // ************************************************************
  // Bus and timing helpers
  // ************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    for (int i = 0; i < 3; i++) chk_word(16'(chan_ctl[i]), 16'h0020);
    chk_bit(bidir_ref, 1'b1);
    chk_bit(unidirectional, 1'b0);
    chk_bit(monitor_ref_negative, 1'b0);
  endtask : t_reset
  // Upper byte dropped, stray write and unmapped read ignored
  task automatic t_regs();
    wr(4'h0, 16'h5a1c);
    rd(4'h0, v);
    chk_word(v, 16'h001c);
    wr(4'h2, 16'h0000);
    rd(4'h0, v);
    chk_word(v, 16'h001c);
    rd(4'h7, v);
    chk_word(v, 16'h0000);
    chk_bit(monitor_ref_negative, 1'b1);
  endtask : t_regs
  // Every gain code, alternating reference mode
  task automatic t_gains();
    for (int g = 0; g < 4; g++) begin
      wr(4'h0, 16'(g * 8 + g % 2));
      step(3);
      chk_word(16'(chan_ctl[2].gain), 16'(g));
      chk_bit(unidirectional, 1'(g % 2));
      chk_bit(bidir_ref, 1'(1 - g % 2));
    end
  endtask : t_gains
  // Channel 0 calibration from unidirectional, gain 10
  task automatic t_cal();
    int n;
    wr(4'h0, 16'h0029);
    for (n = 0; n < 10 && chan_ctl[0].trim_active !== 1'b1; n++) step(1);
    chk_bit(chan_ctl[0].input_short, 1'b1);
    chk_bit(chan_ctl[0].load_disc, 1'b1);
    chk_word(16'(chan_ctl[0].gain), 16'(CSAMC_G40));
    chk_bit(bidir_ref, 1'b1);
    chk_bit(unidirectional, 1'b0);
    chk_word(16'(chan_ctl[1].gain), 16'(CSAMC_G10));
    chk_bit(chan_ctl[1].load_disc, 1'b0);
    for (n = 0; n < 100 && chan_ctl[0].trim_done !== 1'b1; n++) step(1);
    chk_word(16'(n), 16'(TRIM));
    step(10);
    chk_bit(chan_ctl[0].input_short, 1'b1);
    chk_word(16'(chan_ctl[0].gain), 16'(CSAMC_G40));
    wr(4'h0, 16'h0009);
    step(4);
    chk_word(16'(chan_ctl[0].gain), 16'(CSAMC_G10));
    chk_bit(chan_ctl[0].load_disc, 1'b0);
    chk_bit(unidirectional, 1'b1);
  endtask : t_cal
  // Pin request on all channels, dropped mid-trim
  task automatic t_pin();
    int n;
    wr(4'h0, 16'h0000);
    @(posedge mclk);
    cal_pin <= 1'b1;
    idle <= 1'b1;
    for (n = 0; n < 10 && chan_ctl[2].trim_active !== 1'b1; n++) step(1);
    for (int i = 0; i < 3; i++) chk_bit(chan_ctl[i].trim_active, 1'b1);
    step(5);
    @(posedge mclk);
    cal_pin <= 1'b0;
    step(6);
    for (int i = 0; i < 3; i++) chk_bit(chan_ctl[i].input_short, 1'b0);
    chk_word(16'(chan_ctl[0].gain), 16'(CSAMC_G5));
  endtask : t_pin
  // Transistor sense: enable after window, short on turn-off
  task automatic t_fet();
    @(posedge mclk);
    idle <= 1'b0;
    wr(4'h0, 16'h0002);
    step(3);
    chk_bit(monitor_ref_negative, 1'b1);
    chk_bit(chan_ctl[0].amp_en, 1'b0);
    @(posedge mclk);
    fire <= 3'b001;
    @(posedge mclk);
    fire <= 3'b000;
    step(8);
    chk_bit(chan_ctl[0].amp_en, 1'b1);
    chk_bit(chan_ctl[0].pos_sw_node, 1'b1);
    chk_bit(chan_ctl[0].input_short, 1'b0);
    chk_bit(chan_ctl[1].pos_sw_node, 1'b0);
    rd(4'h1, v);
    chk_word(v, 16'h0240);
    @(posedge mclk);
    off_req <= 3'b001;
    step(4);
    chk_bit(chan_ctl[0].input_short, 1'b1);
    chk_bit(chan_ctl[0].pos_sw_node, 1'b0);
    off_req <= 3'b000;
  endtask : t_fet
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, cal_pin, idle} = 5'h00;
    {reg_addr, reg_wdata, fire, off_req} = 26'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    step(1);
    t_reset();
    t_regs();
    t_gains();
    t_cal();
    t_pin();
    t_fet();
    tally_and_finish();
  end
endmodule : csamc_top_tb
